// ===== hdl/dpf_consts.svh
`ifndef DPF_CONSTS_SVH
`define DPF_CONSTS_SVH

// core clock figures
`define DPF_CLK_MHZ            250
`define DPF_NV_PROGRAM_TIME_MS 5
// longest programming time in cycles, the exact product of milliseconds, MHz and 1000
`define DPF_NV_PROGRAM_CYCLES  (`DPF_NV_PROGRAM_TIME_MS * `DPF_CLK_MHZ * 1000)
`define DPF_TIMER_W            21

// byte framing
`define DPF_BITS_PER_BYTE      4'h8
`define DPF_LAST_BIT           4'h7

// instruction byte fields
`define DPF_OPC_MSB            7
`define DPF_OPC_LSB            4
`define DPF_WIPER_BIT          2
`define DPF_SLOT_MSB           1
`define DPF_SLOT_LSB           0

// opcodes handled by the core
`define DPF_OP_RD_WIPER        4'h9
`define DPF_OP_WR_WIPER        4'ha
`define DPF_OP_RD_SLOT         4'hb
`define DPF_OP_WR_SLOT         4'hc
`define DPF_OP_XFR_S2W         4'hd
`define DPF_OP_XFR_W2S         4'he

// widths
`define DPF_POS_W              6
`define DPF_MEM_AW             3

`endif

// ===== hdl/dpf_pkg.sv
`include "dpf_consts.svh"

package dpf_pkg;

    // link side protocol states
    typedef enum logic [3:0]
    {
        LS_IDLE,
        LS_ADDR,
        LS_ADDR_ACK,
        LS_INSTR,
        LS_INSTR_ACK,
        LS_WDATA,
        LS_DATA_ACK,
        LS_RDATA,
        LS_RACK,
        LS_RACK_OK,
        LS_IGNORE
    } dpf_link_e;

    // core side pending memory reads
    typedef enum logic [2:0]
    {
        PD_NONE,
        PD_RD_A,
        PD_RD_B,
        PD_XF_A,
        PD_XF_B
    } dpf_pend_e;

    // link domain state
    typedef struct packed
    {
        logic                  scl_s1;
        logic                  scl_s2;
        logic                  scl_d;
        logic                  sda_s1;
        logic                  sda_s2;
        logic                  sda_d;
        logic                  rst_s1;
        logic                  rst_s2;
        logic                  busy_s1;
        logic                  busy_s2;
        logic                  rack_s1;
        logic                  rack_s2;
        logic                  rack_d;
        logic [3:0]            strap_s1;
        logic [3:0]            strap_s2;
        dpf_link_e             state;
        logic [3:0]            cnt;
        logic [7:0]            shreg;
        logic [7:0]            instr;
        logic [7:0]            data;
        logic [`DPF_POS_W-1:0] rd_word;
        logic                  got_data;
        logic                  sda_oe;
        logic                  drv;
        logic                  cmd_tgl;
        logic                  rdq_tgl;
    } dpf_link_s;

    // core domain state
    typedef struct packed
    {
        logic                    cmd_s1;
        logic                    cmd_s2;
        logic                    cmd_d;
        logic                    rdq_s1;
        logic                    rdq_s2;
        logic                    rdq_d;
        logic [`DPF_POS_W-1:0]   wiper0;
        logic [`DPF_POS_W-1:0]   wiper1;
        logic                    busy;
        logic [`DPF_TIMER_W-1:0] timer;
        dpf_pend_e               pend;
        logic [`DPF_POS_W-1:0]   rd_data;
        logic                    rack_tgl;
        logic [3:0]              opcode;
        logic                    wsel;
        logic [1:0]              slot;
        logic                    mem_we;
        logic [`DPF_MEM_AW-1:0]  mem_waddr;
        logic [`DPF_POS_W-1:0]   mem_wdata;
        logic [`DPF_MEM_AW-1:0]  mem_raddr;
    } dpf_core_s;

endpackage

// ===== hdl/dpf_nvmem.sv
`timescale 1ns/1ns
`include "dpf_consts.svh"

module dpf_nvmem
(
    input  wire logic                   clock,
    input  wire logic                   we,
    input  wire logic [`DPF_MEM_AW-1:0] waddr,
    input  wire logic [`DPF_POS_W-1:0]  wdata,
    input  wire logic [`DPF_MEM_AW-1:0] raddr,
    output logic      [`DPF_POS_W-1:0]  rdata
);

    // two pots times four slots of wiper positions
    logic [`DPF_POS_W-1:0] mem [0:(1<<`DPF_MEM_AW)-1];

    // one write port, registered read port
    always_ff @(posedge clock)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule // dpf_nvmem

// ===== hdl/dpf_slave.sv
`timescale 1ns/1ns
`include "dpf_consts.svh"

module dpf_slave
#(
    parameter int NV_PROG_CYCLES = `DPF_NV_PROGRAM_CYCLES, // programming length in clock cycles
    parameter logic [3:0] DEV_TYPE = 4'hc                  // device type code, value arbitrary
)
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  link_clk,
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire logic                  device_addr_bit3,
    input  wire logic                  device_addr_bit2,
    input  wire logic                  device_addr_bit1,
    input  wire logic                  device_addr_bit0,
    output logic [`DPF_POS_W-1:0]      wiper0,
    output logic [`DPF_POS_W-1:0]      wiper1,
    output logic                       nv_busy,
    output logic [3:0]                 instr_opcode,
    output logic                       wiper_select_bit,
    output logic [1:0]                 slot_select
);

    dpf_pkg::dpf_link_s   l;          // link domain state
    dpf_pkg::dpf_link_s   next_l;     // its next value
    dpf_pkg::dpf_core_s   c;          // core domain state
    dpf_pkg::dpf_core_s   next_c;     // its next value
    logic [`DPF_POS_W-1:0] mem_q;     // memory read data

    // memory slot index from wiper bit and slot bits
    function automatic logic [`DPF_MEM_AW-1:0] slot_addr(input logic sel, input logic [1:0] slot);
        slot_addr = {sel, slot};
    endfunction

    // opcode field of an instruction byte
    function automatic logic [3:0] opc(input logic [7:0] ins);
        opc = ins[`DPF_OPC_MSB:`DPF_OPC_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain: bus protocol on the sampling clock

    logic rise;   // clock line rose
    logic fall;   // clock line fell
    logic start;  // start seen
    logic stop;   // stop seen
    logic is_rd;  // held instruction is a read

    // next link state
    always_comb
    begin
        next_l          = l;
        next_l.scl_s1   = scl;
        next_l.scl_s2   = l.scl_s1;
        next_l.scl_d    = l.scl_s2;
        next_l.sda_s1   = sda_in;
        next_l.sda_s2   = l.sda_s1;
        next_l.sda_d    = l.sda_s2;
        next_l.rst_s1   = rst;
        next_l.rst_s2   = l.rst_s1;
        next_l.busy_s1  = c.busy;
        next_l.busy_s2  = l.busy_s1;
        next_l.rack_s1  = c.rack_tgl;
        next_l.rack_s2  = l.rack_s1;
        next_l.rack_d   = l.rack_s2;
        next_l.strap_s1 = {device_addr_bit3, device_addr_bit2, device_addr_bit1, device_addr_bit0};
        next_l.strap_s2 = l.strap_s1;
        next_l.drv      = 1'b0;
        rise  = l.scl_s2 & ~l.scl_d;
        fall  = ~l.scl_s2 & l.scl_d;
        start = l.scl_s2 & l.scl_d & l.sda_d & ~l.sda_s2;
        stop  = l.scl_s2 & l.scl_d & ~l.sda_d & l.sda_s2;
        is_rd = (opc(l.instr) == `DPF_OP_RD_WIPER) || (opc(l.instr) == `DPF_OP_RD_SLOT);
        // read word is stable once the answer toggle arrives
        if (l.rack_s2 != l.rack_d)
        begin
            next_l.rd_word = c.rd_data;
        end
        if (l.rst_s2)
        begin
            next_l.state    = dpf_pkg::LS_IDLE;
            next_l.cnt      = 4'h0;
            next_l.shreg    = 8'h00;
            next_l.instr    = 8'h00;
            next_l.data     = 8'h00;
            next_l.rd_word  = '0;
            next_l.got_data = 1'b0;
            next_l.sda_oe   = 1'b0;
            next_l.cmd_tgl  = 1'b0;
            next_l.rdq_tgl  = 1'b0;
        end
        else if (start)
        begin
            // any start, repeated or not, restarts addressing
            next_l.state    = dpf_pkg::LS_ADDR;
            next_l.cnt      = 4'h0;
            next_l.sda_oe   = 1'b0;
            next_l.got_data = 1'b0;
        end
        else if (stop)
        begin
            // completed write is handed to the core at stop
            if (l.got_data)
            begin
                next_l.cmd_tgl = ~l.cmd_tgl;
            end
            next_l.state    = dpf_pkg::LS_IDLE;
            next_l.sda_oe   = 1'b0;
            next_l.got_data = 1'b0;
        end
        else
        begin
            unique case (l.state)
                dpf_pkg::LS_IDLE, dpf_pkg::LS_IGNORE:
                begin
                    next_l.sda_oe = 1'b0;
                end
                dpf_pkg::LS_ADDR, dpf_pkg::LS_INSTR, dpf_pkg::LS_WDATA:
                begin
                    // sample on rise, judge the byte on the eighth fall
                    if (rise)
                    begin
                        next_l.shreg = {l.shreg[6:0], l.sda_s2};
                        next_l.cnt   = l.cnt + 4'h1;
                    end
                    if (fall && l.cnt == `DPF_BITS_PER_BYTE)
                    begin
                        next_l.cnt = 4'h0;
                        if (l.state == dpf_pkg::LS_ADDR)
                        begin
                            // match type and straps, and not programming
                            if (l.shreg[7:4] == DEV_TYPE && l.shreg[3:0] == l.strap_s2 && !l.busy_s2)
                            begin
                                next_l.sda_oe = 1'b1;
                                next_l.state  = dpf_pkg::LS_ADDR_ACK;
                            end
                            else
                            begin
                                next_l.state  = dpf_pkg::LS_IGNORE;
                            end
                        end
                        else if (l.state == dpf_pkg::LS_INSTR)
                        begin
                            next_l.instr  = l.shreg;
                            next_l.sda_oe = 1'b1;
                            next_l.state  = dpf_pkg::LS_INSTR_ACK;
                            if (opc(l.shreg) == `DPF_OP_RD_WIPER || opc(l.shreg) == `DPF_OP_RD_SLOT)
                            begin
                                next_l.rdq_tgl = ~l.rdq_tgl;
                            end
                        end
                        else
                        begin
                            next_l.data     = l.shreg;
                            next_l.got_data = 1'b1;
                            next_l.sda_oe   = 1'b1;
                            next_l.state    = dpf_pkg::LS_DATA_ACK;
                        end
                    end
                end
                dpf_pkg::LS_ADDR_ACK:
                begin
                    // release at the end of the ninth clock
                    if (fall)
                    begin
                        next_l.sda_oe = 1'b0;
                        next_l.state  = dpf_pkg::LS_INSTR;
                    end
                end
                dpf_pkg::LS_INSTR_ACK:
                begin
                    if (fall && is_rd)
                    begin
                        // first read bit goes out right away
                        next_l.shreg  = {2'b00, l.rd_word};
                        next_l.sda_oe = 1'b1;
                        next_l.cnt    = 4'h0;
                        next_l.state  = dpf_pkg::LS_RDATA;
                    end
                    else if (fall)
                    begin
                        next_l.sda_oe = 1'b0;
                        next_l.state  = dpf_pkg::LS_WDATA;
                    end
                end
                dpf_pkg::LS_DATA_ACK:
                begin
                    // further bytes are also taken and acknowledged
                    if (fall)
                    begin
                        next_l.sda_oe = 1'b0;
                        next_l.state  = dpf_pkg::LS_WDATA;
                    end
                end
                dpf_pkg::LS_RDATA:
                begin
                    // shift out msb first, drive low for a zero bit
                    if (fall && l.cnt == `DPF_LAST_BIT)
                    begin
                        next_l.sda_oe = 1'b0;
                        next_l.cnt    = 4'h0;
                        next_l.state  = dpf_pkg::LS_RACK;
                    end
                    else if (fall)
                    begin
                        next_l.shreg  = {l.shreg[6:0], 1'b0};
                        next_l.sda_oe = ~l.shreg[6];
                        next_l.cnt    = l.cnt + 4'h1;
                    end
                end
                dpf_pkg::LS_RACK:
                begin
                    // master acknowledge sampled on the ninth rise
                    if (rise)
                    begin
                        next_l.state = l.sda_s2 ? dpf_pkg::LS_IGNORE : dpf_pkg::LS_RACK_OK;
                    end
                end
                dpf_pkg::LS_RACK_OK:
                begin
                    // acknowledged: send the word again
                    if (fall)
                    begin
                        next_l.shreg  = {2'b00, l.rd_word};
                        next_l.sda_oe = 1'b1;
                        next_l.cnt    = 4'h0;
                        next_l.state  = dpf_pkg::LS_RDATA;
                    end
                end
            endcase
        end
    end

    // link state register
    always_ff @(posedge link_clk)
    begin
        l <= next_l;
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain: registers, memory and programming timer

    logic cmd_ev;       // write command arrived
    logic rdq_ev;       // read request arrived
    logic [3:0] op;     // opcode of held instruction
    logic wsel;         // wiper bit of held instruction
    logic [1:0] slot;   // slot bits of held instruction

    // next core state
    always_comb
    begin
        next_c        = c;
        next_c.cmd_s1 = l.cmd_tgl;
        next_c.cmd_s2 = c.cmd_s1;
        next_c.cmd_d  = c.cmd_s2;
        next_c.rdq_s1 = l.rdq_tgl;
        next_c.rdq_s2 = c.rdq_s1;
        next_c.rdq_d  = c.rdq_s2;
        next_c.mem_we = 1'b0;
        cmd_ev = c.cmd_s2 != c.cmd_d;
        rdq_ev = c.rdq_s2 != c.rdq_d;
        op   = opc(l.instr);
        wsel = l.instr[`DPF_WIPER_BIT];
        slot = l.instr[`DPF_SLOT_MSB:`DPF_SLOT_LSB];
        // programming timer, busy for exactly the programmed count
        if (c.busy)
        begin
            next_c.timer = c.timer - `DPF_TIMER_W'(1);
            if (c.timer == `DPF_TIMER_W'(1))
            begin
                next_c.busy = 1'b0;
            end
        end
        if (cmd_ev || rdq_ev)
        begin
            next_c.opcode    = op;
            next_c.wsel      = wsel;
            next_c.slot      = slot;
            next_c.mem_raddr = slot_addr(wsel, slot);
        end
        if (cmd_ev)
        begin
            unique case (op)
                `DPF_OP_WR_WIPER:
                begin
                    if (wsel)
                        next_c.wiper1 = l.data[`DPF_POS_W-1:0];
                    else
                        next_c.wiper0 = l.data[`DPF_POS_W-1:0];
                end
                `DPF_OP_WR_SLOT, `DPF_OP_XFR_W2S:
                begin
                    // slot write starts the programming cycle
                    next_c.mem_we    = 1'b1;
                    next_c.mem_waddr = slot_addr(wsel, slot);
                    next_c.mem_wdata = (op == `DPF_OP_WR_SLOT) ? l.data[`DPF_POS_W-1:0]
                                     : (wsel ? c.wiper1 : c.wiper0);
                    next_c.busy      = 1'b1;
                    next_c.timer     = `DPF_TIMER_W'(NV_PROG_CYCLES);
                end
                `DPF_OP_XFR_S2W:
                begin
                    next_c.pend = dpf_pkg::PD_XF_A;
                end
                default:
                begin
                    // other opcodes carry no write action here
                end
            endcase
        end
        else if (rdq_ev)
        begin
            if (op == `DPF_OP_RD_WIPER)
            begin
                next_c.rd_data  = wsel ? c.wiper1 : c.wiper0;
                next_c.rack_tgl = ~c.rack_tgl;
            end
            else
            begin
                next_c.pend = dpf_pkg::PD_RD_A;
            end
        end
        // memory read takes two cycles
        unique case (c.pend)
            dpf_pkg::PD_NONE: ;
            dpf_pkg::PD_RD_A: next_c.pend = dpf_pkg::PD_RD_B;
            dpf_pkg::PD_XF_A: next_c.pend = dpf_pkg::PD_XF_B;
            dpf_pkg::PD_RD_B:
            begin
                next_c.rd_data  = mem_q;
                next_c.rack_tgl = ~c.rack_tgl;
                next_c.pend     = dpf_pkg::PD_NONE;
            end
            dpf_pkg::PD_XF_B:
            begin
                if (c.wsel)
                    next_c.wiper1 = mem_q;
                else
                    next_c.wiper0 = mem_q;
                next_c.pend = dpf_pkg::PD_NONE;
            end
        endcase
        if (rst)
        begin
            next_c.wiper0   = '0;
            next_c.wiper1   = '0;
            next_c.busy     = 1'b0;
            next_c.timer    = '0;
            next_c.pend     = dpf_pkg::PD_NONE;
            next_c.rd_data  = '0;
            next_c.rack_tgl = 1'b0;
            next_c.opcode   = 4'h0;
            next_c.wsel     = 1'b0;
            next_c.slot     = 2'h0;
            next_c.mem_we   = 1'b0;
            next_c.cmd_d    = 1'b0;
            next_c.cmd_s2   = 1'b0;
            next_c.rdq_d    = 1'b0;
            next_c.rdq_s2   = 1'b0;
        end
    end

    // core state register
    always_ff @(posedge clock)
    begin
        c <= next_c;
    end

    // slot storage
    dpf_nvmem u_mem
    (
        .clock (clock),
        .we    (c.mem_we),
        .waddr (c.mem_waddr),
        .wdata (c.mem_wdata),
        .raddr (c.mem_raddr),
        .rdata (mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from state flops

    assign sda_out          = l.drv;
    assign sda_oe           = l.sda_oe;
    assign wiper0           = c.wiper0;
    assign wiper1           = c.wiper1;
    assign nv_busy          = c.busy;
    assign instr_opcode     = c.opcode;
    assign wiper_select_bit = c.wsel;
    assign slot_select      = c.slot;

endmodule // dpf_slave

// ===== hdl/_unused_placeholder_never.sv
// holds no logic

// ===== sim/dpf_slave_sva.sv
`timescale 1ns/1ns
module dpf_slave_sva
#(
    parameter int NV_PROG_CYCLES = 2000 // programming length in cycles
)
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       link_clk,
    input wire logic       scl,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [5:0] wiper0,
    input wire logic [5:0] wiper1,
    input wire logic       nv_busy
);
    logic [20:0] busy_len; // cycles spent busy so far
    // count the busy span
    always_ff @(posedge clock)
    begin
        busy_len <= (rst || !nv_busy) ? 21'h0 : busy_len + 21'h1;
    end
    // both lines high: the level a stop leaves behind
    sequence s_stop_lvl;
        scl && sda_in;
    endsequence
    a_busy_bound: assert property (@(posedge clock) disable iff (rst) busy_len <= NV_PROG_CYCLES)
        else $error("programming too long");
    a_busy_span: assert property (@(posedge clock) disable iff (rst) $rose(nv_busy) |=> nv_busy[*8])
        else $error("programming too short");
    a_busy_stop: assert property (@(posedge clock) disable iff (rst) $rose(nv_busy) |-> s_stop_lvl)
        else $error("programming not after stop");
    a_busy_silent: assert property (@(posedge clock) disable iff (rst) nv_busy |-> !sda_oe)
        else $error("drive while programming");
    a_wiper0_stop: assert property (@(posedge clock) disable iff (rst) $changed(wiper0) |-> s_stop_lvl)
        else $error("wiper0 moved mid frame");
    a_wiper1_stop: assert property (@(posedge clock) disable iff (rst) $changed(wiper1) |-> s_stop_lvl)
        else $error("wiper1 moved mid frame");
    a_reset_clear: assert property (@(posedge clock) rst |=> !nv_busy && wiper0 == 6'h0 && wiper1 == 6'h0)
        else $error("reset left state");
    a_drive_low: assert property (@(posedge link_clk) disable iff (rst) sda_oe |-> !sda_out)
        else $error("data drive not low");
    a_ack_rise: assert property (@(posedge link_clk) disable iff (rst) $rose(sda_oe) |-> !scl)
        else $error("drive began in clock high");
    a_ack_fall: assert property (@(posedge link_clk) disable iff (rst) $fell(sda_oe) |-> !scl)
        else $error("drive ended in clock high");
endmodule // dpf_slave_sva
bind dpf_slave dpf_slave_sva #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) i_dpf_slave_sva (.clock(clock), .rst(rst),
    .link_clk(link_clk), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wiper0(wiper0),
    .wiper1(wiper1), .nv_busy(nv_busy));

// ===== sim/dpf_bus_master.sv
`timescale 1ns/1ns
module dpf_bus_master
(
    input  wire logic link_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    // both lines released at power-up
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // quarter of a bus bit
    task automatic q_wait();
        repeat (6) @(posedge link_clk);
    endtask
    // start from an idle bus
    task automatic start_c();
        q_wait();
        sda_m <= 1'b0;
        q_wait();
        scl <= 1'b0;
    endtask
    // every frame ends in a stop
    task automatic stop_c();
        sda_m <= 1'b0;
        q_wait();
        scl <= 1'b1;
        q_wait();
        sda_m <= 1'b1;
        q_wait();
    endtask
    // eight bits and the ninth; data moves only while clock low
    task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic ack);
        logic [8:0] sh;
        sh = {tx, nine};
        for (int i = 8; i >= 0; i--)
        begin
            sda_m <= sh[i];
            q_wait();
            scl <= 1'b1;
            q_wait();
            @(negedge link_clk);
            sh[i] = sda;
            q_wait();
            scl <= 1'b0;
            q_wait();
        end
        rx = sh[8:1];
        ack = sh[0];
    endtask
endmodule // dpf_bus_master

// ===== sim/pot_i2c_slave_front_end_tb_top.sv
`timescale 1ns/1ns
module pot_i2c_slave_front_end_tb_top;
    logic       clock = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] strap = 4'h6; // strapped address
    logic       scl, sda_m, sda_oe, sda_out, busy, wsel, ack;
    logic [3:0] opc;
    logic [1:0] slot;
    logic [5:0] w0, w1;
    logic [7:0] rx;
    int         fail_count = 0;
    int         cmp_count = 0;
    wire logic  sda = sda_m & ~sda_oe; // pulled-up open-drain wire
    initial forever #2 clock = ~clock;
    initial
    begin
        #5;
        forever #6 link_clk = ~link_clk;
    end
    dpf_slave #(.NV_PROG_CYCLES(2000)) i_dpf_slave (.clock(clock), .rst(rst), .link_clk(link_clk), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .device_addr_bit3(strap[3]), .device_addr_bit2(strap[2]),
        .device_addr_bit1(strap[1]), .device_addr_bit0(strap[0]), .wiper0(w0), .wiper1(w1), .nv_busy(busy),
        .instr_opcode(opc), .wiper_select_bit(wsel), .slot_select(slot));
    dpf_bus_master i_dpf_bus_master (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one byte, ninth bit compared
    task automatic xb(input logic [7:0] tx, input logic nine, input logic exp);
        i_dpf_bus_master.xfer(tx, nine, rx, ack);
        check("ninth bit", {7'h0, ack}, {7'h0, exp});
    endtask
    // three-byte write
    task automatic cmd(input logic [7:0] ins, input logic [7:0] dat);
        i_dpf_bus_master.start_c();
        xb({4'hc, strap}, 1'b1, 1'b0);
        xb(ins, 1'b1, 1'b0);
        xb(dat, 1'b1, 1'b0);
        i_dpf_bus_master.stop_c();
        repeat (10) @(posedge clock);
    endtask
    // read: ack once, nack, then the line is released
    task automatic rd(input logic [7:0] ins, input logic [7:0] exp);
        i_dpf_bus_master.start_c();
        xb({4'hc, strap}, 1'b1, 1'b0);
        xb(ins, 1'b1, 1'b0);
        xb(8'hff, 1'b0, 1'b0);
        check("read first", rx, exp);
        xb(8'hff, 1'b1, 1'b1);
        check("read again", rx, exp);
        xb(8'hff, 1'b1, 1'b1);
        check("after nack", rx, 8'hff);
        i_dpf_bus_master.stop_c();
    endtask
    // address polling around a programming cycle
    task automatic poll();
        check("busy", {7'h0, busy}, 8'h01);
        i_dpf_bus_master.start_c();
        xb({4'hc, strap}, 1'b1, 1'b1);
        i_dpf_bus_master.stop_c();
        for (int i = 0; i < 2500 && busy !== 1'b0; i++)
            @(posedge clock);
        i_dpf_bus_master.start_c();
        xb({4'hc, strap}, 1'b1, 1'b0);
        i_dpf_bus_master.stop_c();
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (20) @(posedge link_clk);
        xb({4'hc, strap}, 1'b1, 1'b1);
        i_dpf_bus_master.stop_c();
        cmd(8'ha0, 8'h15);
        check("wiper0", {2'h0, w0}, 8'h15);
        cmd(8'ha4, 8'h2a);
        check("wiper1", {2'h0, w1}, 8'h2a);
        check("opcode", {4'h0, opc}, 8'h0a);
        check("wiper select", {7'h0, wsel}, 8'h01);
        rd(8'h94, 8'h2a);
        for (int s = 0; s < 4; s++)
        begin
            cmd({6'h31, s[1:0]}, 8'h10 + s[7:0]);
            poll();
            check("slot", {6'h0, slot}, s[7:0]);
            rd({6'h2d, s[1:0]}, 8'h10 + s[7:0]);
        end
        cmd(8'hd6, 8'h00);
        check("slot to wiper", {2'h0, w1}, 8'h12);
        cmd(8'he3, 8'h00);
        poll();
        rd(8'hb3, 8'h15);
        i_dpf_bus_master.start_c();
        xb({4'hc, strap ^ 4'h1}, 1'b1, 1'b1);
        xb(8'ha0, 1'b1, 1'b1);
        xb(8'h3f, 1'b1, 1'b1);
        i_dpf_bus_master.stop_c();
        i_dpf_bus_master.start_c();
        xb({4'hd, strap}, 1'b1, 1'b1);
        i_dpf_bus_master.stop_c();
        check("wiper0 kept", {2'h0, w0}, 8'h15);
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        #400000;
        fail_count++;
        tally_and_finish();
    end
endmodule // pot_i2c_slave_front_end_tb_top
